/* File: verilog/ppc_top.sv */
// Control and status bits of the pager power-management block.
`timescale 1ns/100ps
`default_nettype none
`include "ppc_params.svh"
module ppc_top (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clk_link_i,
    input wire logic link_cs_n_i,
    input wire logic link_sdi_i,
    output logic link_sdo_o,
    output logic link_sdo_oe_o,
    input wire logic run_pin_i,
    input wire logic switch2_gate_input_i,
    input wire logic reset_sense_input_i,
    input wire logic low_batt_sense_input_i,
    input wire logic channel_a_above_i,
    output logic run_mode_o,
    output logic switch1_output_o,
    output logic switch2_output_o,
    output logic reset_out_pin_oe_o,
    output logic low_batt_out_pin_oe_o,
    output logic aux_1v_supply_enable_o,
    output logic converter_enable_o,
    output logic backup_regulate_o,
    output logic low_charge_select_o,
    output logic [`PPC_VOUT_W-1:0] vout_code_o,
    output logic [`PPC_THRESH_W-1:0] channel_a_threshold_o,
    output logic [2:0] pll_multiplier_o
);
    import ppc_pkg::*;

    // =================================================================
    // Reset release and input synchronisers.
    logic rst_n_sys;
    logic [5:0] pins_s;
    logic tog_s, run_s, gate_s, rsense_s, lb_s, cha_s;
    ppc_cmd_type cmd;
    logic cmd_toggle;

    ppc_sync #(.WIDTH(1)) u_rst_sync (
        .clk_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .d_i(1'b1),
        .q_o(rst_n_sys)
    );

    // The toggle crosses as a level; the command word it announces
    // stays still for a whole frame, far longer than the sync delay.
    ppc_sync #(.WIDTH(6)) u_pin_sync (
        .clk_i(clk_sys_i),
        .rst_n_i(rst_n_sys),
        .d_i({cmd_toggle, run_pin_i, switch2_gate_input_i,
              reset_sense_input_i, low_batt_sense_input_i,
              channel_a_above_i}),
        .q_o(pins_s)
    );

    assign {tog_s, run_s, gate_s, rsense_s, lb_s, cha_s} = pins_s;

    // =================================================================
    // Serial port on the host's clock.
    logic [31:0] image;

    ppc_link u_link (
        .clk_link_i(clk_link_i),
        .rst_n_i(rst_n_i),
        .cs_n_i(link_cs_n_i),
        .sdi_i(link_sdi_i),
        .image_i(image),
        .cmd_o(cmd),
        .cmd_toggle_o(cmd_toggle),
        .sdo_o(link_sdo_o),
        .sdo_oe_o(link_sdo_oe_o)
    );

    // =================================================================
    // Serial registers.
    ppc_ctrl_type ctrl, next_ctrl;
    logic [`PPC_VOUT_W-1:0] vout, next_vout;
    logic [`PPC_THRESH_W-1:0] thresh, next_thresh;
    logic toggle_seen, next_toggle_seen;
    logic wr_event;

    // A write is announced by a flip of the crossed toggle; the command
    // word itself has stood still since the end of its frame.
    assign wr_event = (tog_s != toggle_seen) && cmd.wr;

    // A high reset sense beats any write landing in the same cycle.
    always_comb begin
        next_ctrl = ctrl;
        next_vout = vout;
        next_thresh = thresh;
        next_toggle_seen = tog_s;
        if (rsense_s) begin
            next_ctrl = `PPC_CTRL_RST;
            next_vout = `PPC_VOUT_RST;
            next_thresh = `PPC_THRESH_RST;
        end else if (wr_event) begin
            case (cmd.addr)
                `PPC_ADDR_CTRL: begin
                    next_ctrl = cmd.data[`PPC_CTRL_W-1:0];
                end
                `PPC_ADDR_VOUT: begin
                    next_vout = cmd.data[`PPC_VOUT_W-1:0];
                end
                `PPC_ADDR_THRESH: begin
                    next_thresh = cmd.data[`PPC_THRESH_W-1:0];
                end
                default: begin
                    // Status and unused indices ignore writes.
                end
            endcase
        end
    end

    // Register stage only; the power-on values also stand while the
    // system reset is held.
    always_ff @(posedge clk_sys_i or negedge rst_n_sys) begin
        if (!rst_n_sys) begin
            ctrl <= `PPC_CTRL_RST;
            vout <= `PPC_VOUT_RST;
            thresh <= `PPC_THRESH_RST;
            toggle_seen <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            vout <= next_vout;
            thresh <= next_thresh;
            toggle_seen <= next_toggle_seen;
        end
    end

    // =================================================================
    // Outputs and the read image, all registered.
    logic next_run, next_sw1, next_sw2, next_rst_oe, next_lb_oe;
    logic next_aux, next_conv, next_backup, next_lowchg;
    logic [2:0] next_pll;
    logic [31:0] next_image;

    // The read image is rebuilt every cycle so that status shows the
    // comparators as they stand now, not as of some earlier event.
    always_comb begin
        next_run = run_s | ctrl.run_bit;
        next_sw1 = ctrl.sw1;
        next_sw2 = ctrl.sw2_en & gate_s;
        next_rst_oe = rsense_s;
        next_lb_oe = lb_s;
        next_aux = ctrl.aux_en;
        next_conv = ~ctrl.backup_reg;
        next_backup = ctrl.backup_reg;
        next_lowchg = ctrl.low_charge;
        next_pll = (next_run && next_conv) ? `PPC_PWM_MULT : 3'h0;
        next_image = {6'h00, lb_s, cha_s, 1'b0, thresh, 3'h0, vout,
                      2'h0, ctrl};
    end

    // Output flops; during reset the reset pin is pulled and the
    // converter is left on, as it would be at power-up.
    always_ff @(posedge clk_sys_i or negedge rst_n_sys) begin
        if (!rst_n_sys) begin
            run_mode_o <= 1'b0;
            switch1_output_o <= 1'b0;
            switch2_output_o <= 1'b0;
            reset_out_pin_oe_o <= 1'b1;
            low_batt_out_pin_oe_o <= 1'b0;
            aux_1v_supply_enable_o <= 1'b0;
            converter_enable_o <= 1'b1;
            backup_regulate_o <= 1'b0;
            low_charge_select_o <= 1'b0;
            vout_code_o <= `PPC_VOUT_RST;
            channel_a_threshold_o <= `PPC_THRESH_RST;
            pll_multiplier_o <= 3'h0;
            image <= 32'h0000_0000;
        end else begin
            run_mode_o <= next_run;
            switch1_output_o <= next_sw1;
            switch2_output_o <= next_sw2;
            reset_out_pin_oe_o <= next_rst_oe;
            low_batt_out_pin_oe_o <= next_lb_oe;
            aux_1v_supply_enable_o <= next_aux;
            converter_enable_o <= next_conv;
            backup_regulate_o <= next_backup;
            low_charge_select_o <= next_lowchg;
            vout_code_o <= vout;
            channel_a_threshold_o <= thresh;
            pll_multiplier_o <= next_pll;
            image <= next_image;
        end
    end

    // =================================================================
    // Checks on the system clock.
    default clocking cb_sys @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_sys);

    run_select_a: assert property (
        (run_s || ctrl.run_bit) |=> run_mode_o)
        else $error("run mode not selected by pin or bit");

    coast_entry_a: assert property (
        (!run_s && !ctrl.run_bit) |=> !run_mode_o)
        else $error("coast not entered with pin and bit low");

    sw2_gate_a: assert property (
        ##1 (switch2_output_o == ($past(ctrl.sw2_en) && $past(gate_s))))
        else $error("switch2 is not the AND of bit and gate");

    sw1_write_a: assert property (
        (wr_event && cmd.addr == `PPC_ADDR_CTRL && !rsense_s)
        |=> ##1 (switch1_output_o == $past(cmd.data[`PPC_CTRL_SW1], 2)))
        else $error("switch1 does not follow its written bit");

    por_clear_a: assert property (
        rsense_s |=> (ctrl == `PPC_CTRL_RST && vout == `PPC_VOUT_RST
                      && thresh == `PPC_THRESH_RST && reset_out_pin_oe_o))
        else $error("reset sense did not restore power-on state");

    reset_hold_a: assert property (
        rsense_s [*2] |=> (!switch1_output_o && !aux_1v_supply_enable_o
                           && !backup_regulate_o))
        else $error("outputs not held off during reset sense");

    aux_bit_a: assert property (
        $changed(ctrl.aux_en)
        |=> (aux_1v_supply_enable_o == $past(ctrl.aux_en)))
        else $error("auxiliary supply does not track its bit");

    backup_off_a: assert property (
        backup_regulate_o |-> !converter_enable_o && pll_multiplier_o == 3'h0)
        else $error("converter running during backup regulation");

    charge_sel_a: assert property (
        ctrl.low_charge |=> low_charge_select_o)
        else $error("low charge bit did not select low current");

    chan_status_a: assert property (
        ##1 (image[24 + `PPC_STAT_CHA] == $past(cha_s)))
        else $error("channel A result missing from status");

    lowbatt_a: assert property (
        lb_s |=> (low_batt_out_pin_oe_o && image[24 + `PPC_STAT_LB]))
        else $error("low battery not on pin and status together");

    pwm_mult_a: assert property (
        (run_mode_o && converter_enable_o)
        |-> (pll_multiplier_o == `PPC_PWM_MULT))
        else $error("run rate multiplier is not seven");

    vout_write_a: assert property (
        (wr_event && cmd.addr == `PPC_ADDR_VOUT && !rsense_s)
        |=> (vout == $past(cmd.data[`PPC_VOUT_W-1:0]))
        ##1 (vout_code_o == $past(vout)))
        else $error("output voltage code not taken");

    status_ro_a: assert property (
        (wr_event && cmd.addr == `PPC_ADDR_STATUS && !rsense_s)
        |=> ($stable(ctrl) && $stable(vout) && $stable(thresh)))
        else $error("write to status changed a register");

    // =================================================================
    // Release checks: each bit but backup_reg must also let its output go again; threshold write too.
    sw1_follow_a: assert property (
        ##1 (switch1_output_o == $past(ctrl.sw1)))
        else $error("switch1 not driven by its bit alone");

    // Three quiet cycles keep the reset-time value of the pin flop out.
    rst_release_a: assert property (
        !rsense_s [*3] |-> !reset_out_pin_oe_o)
        else $error("reset pin pulled with reset sense clear");

    aux_off_a: assert property (
        !ctrl.aux_en |=> !aux_1v_supply_enable_o)
        else $error("auxiliary supply on with its bit clear");

    backup_bit_a: assert property (
        ctrl.backup_reg |=> (backup_regulate_o && !converter_enable_o))
        else $error("backup bit did not stop the converter");

    high_charge_a: assert property (
        !ctrl.low_charge |=> !low_charge_select_o)
        else $error("high charge current not selected");

    thresh_write_a: assert property (
        (wr_event && cmd.addr == `PPC_ADDR_THRESH && !rsense_s)
        |=> (thresh == $past(cmd.data[`PPC_THRESH_W-1:0])))
        else $error("channel A threshold code not taken");

    lowbatt_off_a: assert property (
        !lb_s |=> (!low_batt_out_pin_oe_o && !image[24 + `PPC_STAT_LB]))
        else $error("low battery shown with comparator clear");

    coast_rate_a: assert property (
        !run_mode_o |-> (pll_multiplier_o == 3'h0))
        else $error("converter rate set while in coast");

    // Main scenarios that the bench is expected to reach.
    ctrl_write_c: cover property (
        wr_event && cmd.addr == `PPC_ADDR_CTRL ##2 run_mode_o);
    backup_c: cover property (backup_regulate_o ##1 !backup_regulate_o);
    lowbatt_c: cover property (lb_s ##2 low_batt_out_pin_oe_o);
    por_c: cover property (rsense_s ##1 !rsense_s);
    sense_write_c: cover property (rsense_s && wr_event);
endmodule
`default_nettype wire

/* File: verilog/ppc_params.svh */
// Constants of the pager power-control block: offsets, fields, resets.
// =====================================================================
// What this block does
// - Run when pin or bit high
// - Switch2 conducts on enable bit AND gate
// - Switch1 follows its serial bit only
// - Reset sense pulls reset pin, clears registers
// - Reset sense also resets chip internally
// - Auxiliary 1V supply enabled by serial bit
// - Backup regulate stops converter, uses backup cell
// - Charger offers high and low currents
// - Channel A result readable in status bit
// - Low battery drives pin and status bit
// - Run converter rate is seven times sync
// - Output voltage set by digital code
// - Low-charge bit one selects low current
// - Coast needs bit cleared and pin low
`ifndef PPC_PARAMS_SVH
`define PPC_PARAMS_SVH
// =====================================================================
// Register indices carried in the frame address field.
`define PPC_ADDR_CTRL 3'h0
`define PPC_ADDR_VOUT 3'h1
`define PPC_ADDR_THRESH 3'h2
`define PPC_ADDR_STATUS 3'h3
// =====================================================================
// Field positions.
`define PPC_CTRL_W 6
`define PPC_CTRL_SW1 1
`define PPC_STAT_CHA 0
`define PPC_STAT_LB 1
`define PPC_VOUT_W 5
`define PPC_THRESH_W 7
// =====================================================================
// Power-on values; output code 12 is 3.0V at 1.8V plus 100mV steps.
`define PPC_CTRL_RST 6'h00
`define PPC_VOUT_RST 5'h0c
`define PPC_THRESH_RST 7'h00
// =====================================================================
// Timing: converter multiplier and frame bit counts.
`define PPC_PWM_MULT 3'h7
`define PPC_HEAD_LAST 4'h7
`define PPC_FRAME_LAST 4'hf
`endif

/* File: verilog/ppc_pkg.sv */
// Types shared by the pager power-control block.
`default_nettype none
package ppc_pkg;
    // Control register fields, most significant first.
    typedef struct packed {
        logic low_charge;
        logic backup_reg;
        logic aux_en;
        logic sw2_en;
        logic sw1;
        logic run_bit;
    } ppc_ctrl_type;

    // One serial frame as captured at the link.
    typedef struct packed {
        logic wr;
        logic [2:0] addr;
        logic [7:0] data;
    } ppc_cmd_type;

    typedef enum logic [1:0] {
        PPC_LS_HEAD = 2'b01,
        PPC_LS_BODY = 2'b10
    } ppc_link_state_type;
endpackage
`default_nettype wire

/* File: verilog/ppc_sync.sv */
// Two-flop level synchroniser of parameterised width.
`timescale 1ns/100ps
`default_nettype none
module ppc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;

    // The first stage feeds only the second one.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/ppc_link.sv */
// Serial port logic running on the host's serial clock.
`timescale 1ns/100ps
`default_nettype none
`include "ppc_params.svh"
module ppc_link (
    input wire logic clk_link_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    input wire logic [31:0] image_i,
    output var ppc_pkg::ppc_cmd_type cmd_o,
    output logic cmd_toggle_o,
    output logic sdo_o,
    output logic sdo_oe_o
);
    import ppc_pkg::*;

    logic frame_rst_n;
    logic [31:0] image_s;
    ppc_link_state_type state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [14:0] sh_in, next_sh_in;
    logic [7:0] sh_out, next_sh_out;
    logic next_oe, next_toggle;
    ppc_cmd_type next_cmd;

    // Byte of the read image for a register index; above three reads 0.
    function automatic logic [7:0] pick_byte(input logic [31:0] img,
                                             input logic [2:0] a);
        pick_byte = a[2] ? 8'h00 : img[{a[1:0], 3'h0} +: 8];
    endfunction

    // Chip select high ends a frame: the clock may stop, so it resets.
    assign frame_rst_n = rst_n_i & ~cs_n_i;
    assign sdo_o = sh_out[7];

    ppc_sync #(.WIDTH(32)) u_img_sync (
        .clk_i(clk_link_i),
        .rst_n_i(rst_n_i),
        .d_i(image_i),
        .q_o(image_s)
    );

    // Header byte: write flag then index; body byte: data, MSB first.
    always_comb begin
        next_state = state;
        next_cnt = cnt + 4'h1;
        next_sh_in = {sh_in[13:0], sdi_i};
        next_sh_out = {sh_out[6:0], 1'b0};
        next_oe = sdo_oe_o;
        next_cmd = cmd_o;
        next_toggle = cmd_toggle_o;
        case (state)
            PPC_LS_HEAD: begin
                if (cnt == `PPC_HEAD_LAST) begin
                    next_state = PPC_LS_BODY;
                    next_oe = 1'b1;
                    next_sh_out = pick_byte(image_s, {sh_in[1:0], sdi_i});
                end
            end
            PPC_LS_BODY: begin
                if (cnt == `PPC_FRAME_LAST) begin
                    next_state = PPC_LS_HEAD;
                    next_cmd = {sh_in[14], sh_in[9:7], sh_in[6:0], sdi_i};
                    if (sh_in[14]) begin
                        next_toggle = ~cmd_toggle_o;
                    end
                end
            end
            default: begin
                next_state = PPC_LS_HEAD;
            end
        endcase
    end

    // Frame state, cleared whenever the chip select is released.
    always_ff @(posedge clk_link_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            state <= PPC_LS_HEAD;
            cnt <= 4'h0;
            sh_in <= 15'h0000;
            sh_out <= 8'h00;
            sdo_oe_o <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            sh_in <= next_sh_in;
            sh_out <= next_sh_out;
            sdo_oe_o <= next_oe;
        end
    end

    // Captured command survives between frames for the system side.
    always_ff @(posedge clk_link_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_o <= '0;
            cmd_toggle_o <= 1'b0;
        end else begin
            cmd_o <= next_cmd;
            cmd_toggle_o <= next_toggle;
        end
    end
endmodule
`default_nettype wire

/* File: tb/ppc_host_model.sv */
// Host side of the serial link: frames sent on request, read byte kept.
`timescale 1ns/100ps
`default_nettype none
module ppc_host_model (
    input wire logic go_i,
    input wire logic [15:0] frame_i,
    input wire logic [4:0] nbits_i,
    input wire logic sdo_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o,
    output logic [7:0] rdata_o,
    output logic done_o
);
    int i;

    // ==================================================================
    // Frame engine
    // The serial clock only runs inside a frame, so the link domain sees
    // no edges between frames, as on a real host.
    initial begin
        sclk_o = 1'h0;
        cs_n_o = 1'h1;
        sdi_o = 1'h0;
        rdata_o = 8'h00;
        done_o = 1'h0;
        forever begin
            wait (go_i === 1'h1);
            cs_n_o = 1'h0;
            // A count under 16 drops select early to abort the frame.
            for (i = 15; i > 15 - int'(nbits_i); i--) begin
                sdi_o = frame_i[i];
                #24;
                // Read bits are taken at the rising edge, before it lands.
                if (i < 8) begin
                    rdata_o[i] = sdo_i;
                end
                sclk_o = 1'h1;
                #24;
                sclk_o = 1'h0;
            end
            #24;
            cs_n_o = 1'h1;
            // A released data line must not keep showing the last bit.
            sdi_o = ~sdi_o;
            done_o = 1'h1;
            wait (go_i === 1'h0);
            done_o = 1'h0;
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the pager power-control bits.
`timescale 1ns/100ps
`default_nettype none
`include "ppc_params.svh"
module tb;
    import ppc_pkg::*;

    typedef struct packed {
        logic [5:0] ctrl;
        logic pin;
        logic gate;
        logic [9:0] outs;
    } ppc_tb_row_type;

    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic run_pin = 1'h0;
    logic gate = 1'h0;
    logic rsense = 1'h0;
    logic lbatt = 1'h0;
    logic cha = 1'h0;
    logic go = 1'h0;
    logic [15:0] frame = 16'h0000;
    logic [4:0] nbits = 5'h10;
    wire logic sclk, cs_n, sdi, sdo, done;
    wire logic sdo_oe, sdo_line;
    logic [9:0] want;
    wire logic [7:0] rdata;
    wire logic run_mode, sw1, sw2, rst_oe, lb_oe, aux, conv, bk, lc;
    wire logic [4:0] vout;
    wire logic [6:0] thr;
    wire logic [2:0] pll;
    wire logic [9:0] outs;
    int bad_count = 0;
    int cmp_count = 0;
    int k;

    // Expected {multiplier, run, sw1, sw2, aux, converter, backup, low}.
    localparam ppc_tb_row_type rows [9] = '{
        {6'h00, 1'h0, 1'h0, 10'h004}, {6'h01, 1'h0, 1'h1, 10'h3c4},
        {6'h00, 1'h1, 1'h1, 10'h3c4}, {6'h04, 1'h0, 1'h1, 10'h014},
        {6'h04, 1'h0, 1'h0, 10'h004}, {6'h02, 1'h0, 1'h1, 10'h024},
        {6'h08, 1'h0, 1'h0, 10'h00c}, {6'h20, 1'h0, 1'h0, 10'h005},
        {6'h11, 1'h0, 1'h0, 10'h042}};

    assign outs = {pll, run_mode, sw1, sw2, aux, conv, bk, lc};

    // Undriven data out shows the inverse of its last bit, so a read
    // taken while the device is not driving comes back wrong.
    assign sdo_line = sdo_oe ? sdo : ~sdo;

    // System clock of 100 ns.
    always #50 clk = ~clk;

    ppc_host_model host (.go_i(go), .frame_i(frame), .nbits_i(nbits),
        .sdo_i(sdo_line), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi),
        .rdata_o(rdata), .done_o(done));

    ppc_top dut (.clk_sys_i(clk), .rst_n_i(rst_n), .clk_link_i(sclk),
        .link_cs_n_i(cs_n), .link_sdi_i(sdi), .link_sdo_o(sdo),
        .link_sdo_oe_o(sdo_oe), .run_pin_i(run_pin),
        .switch2_gate_input_i(gate), .reset_sense_input_i(rsense),
        .low_batt_sense_input_i(lbatt), .channel_a_above_i(cha),
        .run_mode_o(run_mode), .switch1_output_o(sw1),
        .switch2_output_o(sw2), .reset_out_pin_oe_o(rst_oe),
        .low_batt_out_pin_oe_o(lb_oe), .aux_1v_supply_enable_o(aux),
        .converter_enable_o(conv), .backup_regulate_o(bk),
        .low_charge_select_o(lc), .vout_code_o(vout),
        .channel_a_threshold_o(thr), .pll_multiplier_o(pll));

    // ==================================================================
    // Helpers
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask

    // One frame; the wait afterwards covers the crossing into clk_sys.
    task automatic xfer(input logic wr, input logic [2:0] addr,
        input logic [7:0] data, input logic [4:0] nb);
        frame = {wr, 4'h0, addr, data};
        nbits = nb;
        go = 1'h1;
        for (k = 0; k < 60 && done !== 1'h1; k++) begin
            @(negedge clk);
        end
        if (done !== 1'h1) begin
            bad_count++;
            tally_and_finish();
        end else begin
            go = 1'h0;
            cycles(10);
        end
    endtask

    // ==================================================================
    // Main sequence
    initial begin
        cycles(10);
        check("reset pin in reset", rst_oe, 1'h1);
        check("converter in reset", conv, 1'h1);
        check("vout in reset", vout, 5'h0c);
        cycles(2);
        rst_n = 1'h1;
        cycles(8);
        check("reset pin released", rst_oe, 1'h0);
        for (int r = 0; r < 9; r++) begin
            run_pin = rows[r].pin;
            gate = rows[r].gate;
            want = rows[r].outs;
            xfer(1'h1, `PPC_ADDR_CTRL, {2'h0, rows[r].ctrl}, 5'h10);
            check("mode", outs[9:6], want[9:6]);
            check("switch2", outs[4], want[4]);
            check("switch1", outs[5], want[5]);
            check("aux supply", outs[3], want[3]);
            check("backup", outs[2:1], want[2:1]);
            check("charge", outs[0], want[0]);
        end
        // Register write and read back of output code and threshold.
        xfer(1'h1, `PPC_ADDR_VOUT, 8'h1f, 5'h10);
        check("vout code", vout, 5'h1f);
        xfer(1'h0, `PPC_ADDR_VOUT, 8'h00, 5'h10);
        check("vout read", rdata, 8'h1f);
        xfer(1'h1, `PPC_ADDR_THRESH, 8'h7f, 5'h10);
        check("threshold", thr, 7'h7f);
        xfer(1'h0, `PPC_ADDR_THRESH, 8'h00, 5'h10);
        check("threshold read", rdata, 8'h7f);
        // Status is live and ignores writes.
        lbatt = 1'h1;
        cha = 1'h0;
        cycles(6);
        check("low batt pin", lb_oe, 1'h1);
        xfer(1'h1, `PPC_ADDR_STATUS, 8'hff, 5'h10);
        xfer(1'h0, `PPC_ADDR_STATUS, 8'h00, 5'h10);
        check("status read", rdata, 8'h02);
        lbatt = 1'h0;
        cha = 1'h1;
        cycles(6);
        check("low batt pin off", lb_oe, 1'h0);
        xfer(1'h0, `PPC_ADDR_STATUS, 8'h00, 5'h10);
        check("status read", rdata, 8'h01);
        xfer(1'h0, 3'h5, 8'h00, 5'h10);
        check("unmapped read", rdata, 8'h00);
        check("data out released", sdo_oe, 1'h0);
        // An aborted frame must leave the switch untouched.
        xfer(1'h1, `PPC_ADDR_CTRL, 8'h02, 5'h0a);
        check("aborted write", sw1, 1'h0);
        xfer(1'h1, `PPC_ADDR_CTRL, 8'h02, 5'h10);
        check("switch1 on", sw1, 1'h1);
        // Reset sense clears registers and blocks writes while high.
        rsense = 1'h1;
        cycles(6);
        check("reset pin by sense", rst_oe, 1'h1);
        check("switch1 cleared", sw1, 1'h0);
        check("vout cleared", vout, 5'h0c);
        check("threshold cleared", thr, 7'h00);
        xfer(1'h1, `PPC_ADDR_CTRL, 8'h02, 5'h10);
        check("write under sense", sw1, 1'h0);
        rsense = 1'h0;
        cycles(6);
        check("reset pin freed", rst_oe, 1'h0);
        // A second system reset in mid-run.
        xfer(1'h1, `PPC_ADDR_CTRL, 8'h02, 5'h10);
        rst_n = 1'h0;
        cycles(3);
        check("switch1 after reset", sw1, 1'h0);
        rst_n = 1'h1;
        cycles(8);
        check("reset pin after reset", rst_oe, 1'h0);
        check("switch1 after release", sw1, 1'h0);
        xfer(1'h1, `PPC_ADDR_CTRL, 8'h02, 5'h10);
        check("write after release", sw1, 1'h1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
